// >>> reo_host.sv
// serial control host model for the register port
`timescale 1ns/100ps
module reo_host #(
    parameter logic [6:0] DEV = 7'h5e
) (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    // sda_out high is released; the pull-up sets the wire
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask : tick
    // two cycles per phase, three with scl high, so the device sees each level at least twice
    task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            sda_out = tx[i];
            tick(2);
            scl_out = 1'b1;
            tick(2);
            rx[i] = sda_in;
            tick(1);
            scl_out = 1'b0;
            tick(2);
        end
    endtask : bits
    task automatic start();
        sda_out = 1'b1;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        sda_out = 1'b0;
        tick(2);
        scl_out = 1'b0;
        tick(2);
    endtask : start
    task automatic stop();
        sda_out = 1'b0;
        tick(2);
        scl_out = 1'b1;
        tick(2);
        sda_out = 1'b1;
        tick(2);
    endtask : stop
    task automatic wr(input logic [6:0] a, input logic [7:0] p, d, output logic [2:0] nak);
        logic [8:0] r0, r1, r2;
        start();
        bits({a, 2'b01}, r0);
        bits({p, 1'b1}, r1);
        bits({d, 1'b1}, r2);
        stop();
        nak = {r0[0], r1[0], r2[0]};
    endtask : wr
    task automatic rd(input logic [7:0] p, output logic [7:0] q);
        logic [8:0] r;
        start();
        bits({DEV, 2'b01}, r);
        bits({p, 1'b1}, r);
        start();
        bits({DEV, 2'b11}, r);
        bits(9'h1ff, r);
        stop();
        q = r[8:1];
    endtask : rd
    // master ack after the first byte asks for the next register
    task automatic rd2(input logic [7:0] p, output logic [15:0] q);
        logic [8:0] r, r1;
        start();
        bits({DEV, 2'b01}, r);
        bits({p, 1'b1}, r);
        start();
        bits({DEV, 2'b11}, r);
        bits(9'h1fe, r1);
        bits(9'h1ff, r);
        stop();
        q = {r1[8:1], r[8:1]};
    endtask : rd2
endmodule : reo_host

// >>> reo_pkg.sv
// constants, register map and state codes for the rail enable override block
package reo_pkg;
    localparam int REG_W = 8;
    localparam int NUM_RAILS = 12;
    localparam int NUM_BUCKS = 6;
    localparam int NUM_GPO = 4;
    localparam int ADDR_W = 7;

    // register offsets on the serial control port
    localparam logic [7:0] OFF_SWITCH_TERM_DIS = 8'h9f;
    localparam logic [7:0] OFF_FORCE_ON_A = 8'ha0;
    localparam logic [7:0] OFF_FORCE_ON_B = 8'ha1;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // switch/termination disable register fields
    localparam int BIT_TERM_DIS = 4;
    localparam int BIT_SWITCH_A1_DISABLE = 5;
    localparam int BIT_SWITCH_B1_DISABLE = 6;
    localparam int BIT_SHARED_DIS = 7;
    localparam logic [7:0] DIS_RESET = 8'hf0;

    // first force-on register fields
    localparam int BIT_BUCK_LO = 0;
    localparam int BIT_SWITCH_A1_FORCE_ON = 6;
    localparam int BIT_A2_EN = 7;

    // second force-on / output level register fields
    localparam int BIT_A3_EN = 0;
    localparam int BIT_SWITCH_B1_FORCE_ON = 1;
    localparam int BIT_SHARED_EN = 2;
    localparam int BIT_TERM_EN = 3;
    localparam int BIT_LVL_LO = 4;
    localparam logic [7:0] FORCE_RESET = 8'h00;

    // rail indices of the enable vector
    localparam int RAIL_LOAD_SWITCH_A1 = 6;
    localparam int RAIL_A2 = 7;
    localparam int RAIL_A3 = 8;
    localparam int RAIL_LOAD_SWITCH_B1 = 9;
    localparam int RAIL_SHARED = 10;
    localparam int RAIL_TERM = 11;

    // output pin four is open-drain only
    localparam int GPO_FOUR = 3;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [2:0] FIRST_BIT = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_PTR = 4'h2,
        ST_WDATA = 4'h3,
        ST_ACK_WAIT = 4'h4,
        ST_ACK = 4'h5,
        ST_RDATA = 4'h6,
        ST_MACK = 4'h7,
        ST_RNEXT = 4'h8
    } reo_state_t;
endpackage : reo_pkg

// >>> reo_rail_gate.sv
// per-rail gate: disable bit over force-on or pin request
`timescale 1ns/100ps
module reo_rail_gate #(
    parameter int N = reo_pkg::NUM_RAILS
) (
    input wire logic [N-1:0] allow_in,
    input wire logic [N-1:0] force_in,
    input wire logic [N-1:0] request_in,
    output logic [N-1:0] enable_out
);
    generate
        for (genvar i = 0; i < N; i++) begin : g_rail
            // a zero allow bit wins over everything else
            assign enable_out[i] = allow_in[i] & (force_in[i] | request_in[i]); // [R17]
        end
    endgenerate
endmodule : reo_rail_gate

// >>> reo_top.sv
// rail enable override registers with serial control port slave
`timescale 1ns/100ps
// Contract
// [R1] termination disable bit zero forces termination off
// [R2] switch A1 disable bit zero forces it off
// [R3] switch B1 disable bit zero forces it off
// [R4] bit 7 disables the otp-selected shared rail
// [R5] host writes zeros to reserved low bits
// [R6] force-on zero: pins or power-good decide
// [R7] force-on bits 5:0 turn bucks on
// [R8] bit 7 forces regulator A2 on
// [R9] bit 6 forces switch A1 on
// [R10] second register bit 3 forces termination on
// [R11] second register bit 2 forces shared rail on
// [R12] second register bit 1 forces switch B1 on
// [R13] level bit 7 drives open-drain output four
// [R14] level bits 6:4 drive outputs three to one
// [R15] unconfigured outputs follow power-good, bits default zero
// [R16] second register bit 0 forces regulator A3 on
// [R17] enable is disable AND (force OR request)
module reo_top #(
    parameter logic [6:0] DEV_ADDR = 7'h5e,
    parameter logic [7:0] FORCE_A_RESET = reo_pkg::FORCE_RESET,
    parameter logic [7:0] FORCE_B_RESET = reo_pkg::FORCE_RESET
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [reo_pkg::NUM_RAILS-1:0] rail_request_in,
    input wire logic [reo_pkg::NUM_BUCKS-1:0] buck_disable_in,
    input wire logic regulator_a2_disable_in,
    input wire logic regulator_a3_disable_in,
    input wire logic shared_is_switch_b2_in,
    input wire logic [reo_pkg::NUM_GPO-1:0] gpo_reg_ctrl_in,
    input wire logic [reo_pkg::NUM_GPO-1:0] gpo_push_pull_in,
    input wire logic [reo_pkg::NUM_GPO-1:0] gpo_power_good_in,
    output logic [reo_pkg::NUM_RAILS-1:0] rail_en_out,
    output logic load_switch_b2_en_out,
    output logic regulator_a1_en_out,
    output logic [reo_pkg::NUM_GPO-1:0] gpo_out,
    output logic [reo_pkg::NUM_GPO-1:0] gpo_oe_out
);
    // general-call and the reserved address blocks cannot be served
    localparam logic [6:0] ADDR_FIRST = 7'h08;
    localparam logic [6:0] ADDR_LAST = 7'h77;
    if (DEV_ADDR < ADDR_FIRST || DEV_ADDR > ADDR_LAST) begin : g_bad_addr
        $error("reo_top: DEV_ADDR lies in a reserved address block");
    end
    // level bits default to zero; a reset parameter must not change that
    if (FORCE_B_RESET[reo_pkg::BIT_LVL_LO +: reo_pkg::NUM_GPO] != '0) begin : g_bad_lvl
        $error("reo_top: FORCE_B_RESET must leave the level bits zero"); // [R15]
    end
    // the enable vector layout below assumes bucks first, termination last
    if (reo_pkg::RAIL_LOAD_SWITCH_A1 != reo_pkg::NUM_BUCKS
            || reo_pkg::RAIL_TERM != reo_pkg::NUM_RAILS - 1) begin : g_bad_map
        $error("reo_top: rail index map does not fit the enable vector");
    end

    logic [7:0] dis_r;
    logic [7:0] force_a_r;
    logic [7:0] force_b_r;

    // pins count as synchronous; an unrelated host clock would need two more flops
    // serial port sampling and bus conditions
    logic scl_q_r;
    logic sda_q_r;
    wire scl_rise = scl_in & ~scl_q_r;
    wire scl_fall = ~scl_in & scl_q_r;
    wire bus_start = scl_in & scl_q_r & sda_q_r & ~sda_in;
    wire bus_stop = scl_in & scl_q_r & ~sda_q_r & sda_in;

    // one byte engine serves address, pointer, write data and read data
    reo_pkg::reo_state_t state_r;
    reo_pkg::reo_state_t ack_next_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] ptr_r;
    logic ack_drive_r;
    logic sda_oe_r;

    wire last_bit = bit_cnt_r == reo_pkg::LAST_BIT;
    wire [7:0] rx_byte = {shift_r[6:0], sda_in};
    wire rx_done = scl_rise & last_bit;
    wire addr_match = rx_byte[7:1] == DEV_ADDR;
    wire rx_read = rx_byte[0];
    wire wr_strobe = rx_done & (state_r == reo_pkg::ST_WDATA);

    // unmapped offsets read as zero, so probing the map is harmless
    wire sel_dis = ptr_r == reo_pkg::OFF_SWITCH_TERM_DIS;
    wire sel_a = ptr_r == reo_pkg::OFF_FORCE_ON_A;
    wire sel_b = ptr_r == reo_pkg::OFF_FORCE_ON_B;
    wire [7:0] rd_data = sel_dis ? dis_r : sel_a ? force_a_r : sel_b ? force_b_r :
                         reo_pkg::RD_UNMAPPED;

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_in;
            sda_q_r <= sda_in;
        end
    end

    // no clock stretching: reads are answered straight from the register flops
    // byte-level protocol engine; bits sampled on scl rise, driven on scl fall
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_r <= reo_pkg::ST_IDLE;
            ack_next_r <= reo_pkg::ST_IDLE;
            bit_cnt_r <= reo_pkg::FIRST_BIT;
            shift_r <= 8'h00;
            ptr_r <= 8'h00;
            ack_drive_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else if (bus_start) begin
            // repeated start keeps the pointer for register reads
            state_r <= reo_pkg::ST_ADDR;
            bit_cnt_r <= reo_pkg::FIRST_BIT;
            sda_oe_r <= 1'b0;
        end else if (bus_stop) begin
            state_r <= reo_pkg::ST_IDLE;
            sda_oe_r <= 1'b0;
        end else begin
            unique case (state_r)
                reo_pkg::ST_IDLE: begin
                    sda_oe_r <= 1'b0;
                end
                reo_pkg::ST_ADDR, reo_pkg::ST_PTR, reo_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        shift_r <= rx_byte;
                        bit_cnt_r <= bit_cnt_r + 3'h1;
                    end
                    if (rx_done) begin
                        state_r <= reo_pkg::ST_ACK_WAIT;
                        ack_drive_r <= 1'b1;
                        if (state_r == reo_pkg::ST_ADDR) begin
                            ack_drive_r <= addr_match;
                            ack_next_r <= rx_read ? reo_pkg::ST_RDATA : reo_pkg::ST_PTR;
                        end else if (state_r == reo_pkg::ST_PTR) begin
                            ptr_r <= rx_byte;
                            ack_next_r <= reo_pkg::ST_WDATA;
                        end else begin
                            // auto-increment lets a burst walk adjacent registers
                            ptr_r <= ptr_r + 8'h01;
                            ack_next_r <= reo_pkg::ST_WDATA;
                        end
                    end
                end
                reo_pkg::ST_ACK_WAIT: begin
                    if (scl_fall) begin
                        if (ack_drive_r) begin
                            sda_oe_r <= 1'b1;
                            state_r <= reo_pkg::ST_ACK;
                        end else begin
                            // not our address: stay off the bus until the next start
                            state_r <= reo_pkg::ST_IDLE;
                        end
                    end
                end
                reo_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_r <= reo_pkg::FIRST_BIT;
                        if (ack_next_r == reo_pkg::ST_RDATA) begin
                            shift_r <= rd_data;
                            sda_oe_r <= ~rd_data[7];
                            state_r <= reo_pkg::ST_RDATA;
                        end else begin
                            sda_oe_r <= 1'b0;
                            state_r <= ack_next_r;
                        end
                    end
                end
                // bit seven left on the ack fall; seven more falls drive bits six to zero, the eighth releases the line
                reo_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (last_bit) begin
                            sda_oe_r <= 1'b0;
                            state_r <= reo_pkg::ST_MACK;
                        end else begin
                            shift_r <= {shift_r[6:0], 1'b0};
                            sda_oe_r <= ~shift_r[6];
                            bit_cnt_r <= bit_cnt_r + 3'h1;
                        end
                    end
                end
                reo_pkg::ST_MACK: begin
                    if (scl_rise) begin
                        ptr_r <= ptr_r + 8'h01;
                        // the pointer steps on nack too; a new read sets it again
                        // a nack ends the read; the host follows with stop
                        state_r <= sda_in ? reo_pkg::ST_IDLE : reo_pkg::ST_RNEXT;
                    end
                end
                reo_pkg::ST_RNEXT: begin
                    if (scl_fall) begin
                        bit_cnt_r <= reo_pkg::FIRST_BIT;
                        shift_r <= rd_data;
                        sda_oe_r <= ~rd_data[7];
                        state_r <= reo_pkg::ST_RDATA;
                    end
                end
                default: begin
                    state_r <= reo_pkg::ST_IDLE;
                    sda_oe_r <= 1'b0;
                end
            endcase
        end
    end

    // register file; writes to unmapped offsets are dropped
    // only a completed data byte writes; a cut byte leaves the registers alone
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            dis_r <= reo_pkg::DIS_RESET;
            force_a_r <= FORCE_A_RESET;
            force_b_r <= FORCE_B_RESET; // [R15]
        end else if (wr_strobe) begin
            // reserved low bits are stored as written; host keeps them zero
            if (sel_dis) begin
                dis_r <= rx_byte; // [R5]
            end
            if (sel_a) begin
                force_a_r <= rx_byte;
            end
            if (sel_b) begin
                force_b_r <= rx_byte;
            end
        end
    end

    // per-rail allow, force and enable vectors
    logic [reo_pkg::NUM_RAILS-1:0] allow_vec;
    logic [reo_pkg::NUM_RAILS-1:0] force_vec;
    logic [reo_pkg::NUM_RAILS-1:0] enable_vec;

    assign allow_vec[reo_pkg::NUM_BUCKS-1:0] = buck_disable_in;
    assign allow_vec[reo_pkg::RAIL_LOAD_SWITCH_A1] = dis_r[reo_pkg::BIT_SWITCH_A1_DISABLE]; // [R2]
    assign allow_vec[reo_pkg::RAIL_A2] = regulator_a2_disable_in;
    assign allow_vec[reo_pkg::RAIL_A3] = regulator_a3_disable_in;
    assign allow_vec[reo_pkg::RAIL_LOAD_SWITCH_B1] = dis_r[reo_pkg::BIT_SWITCH_B1_DISABLE]; // [R3]
    assign allow_vec[reo_pkg::RAIL_SHARED] = dis_r[reo_pkg::BIT_SHARED_DIS]; // [R4]
    assign allow_vec[reo_pkg::RAIL_TERM] = dis_r[reo_pkg::BIT_TERM_DIS]; // [R1]

    assign force_vec[reo_pkg::NUM_BUCKS-1:0] =
        force_a_r[reo_pkg::BIT_BUCK_LO +: reo_pkg::NUM_BUCKS]; // [R7]
    assign force_vec[reo_pkg::RAIL_LOAD_SWITCH_A1] = force_a_r[reo_pkg::BIT_SWITCH_A1_FORCE_ON]; // [R9]
    assign force_vec[reo_pkg::RAIL_A2] = force_a_r[reo_pkg::BIT_A2_EN]; // [R8]
    assign force_vec[reo_pkg::RAIL_A3] = force_b_r[reo_pkg::BIT_A3_EN]; // [R16]
    assign force_vec[reo_pkg::RAIL_LOAD_SWITCH_B1] = force_b_r[reo_pkg::BIT_SWITCH_B1_FORCE_ON]; // [R12]
    assign force_vec[reo_pkg::RAIL_SHARED] = force_b_r[reo_pkg::BIT_SHARED_EN]; // [R11]
    assign force_vec[reo_pkg::RAIL_TERM] = force_b_r[reo_pkg::BIT_TERM_EN]; // [R10]

    // with force clear, the allow bit and the pin or power-good request decide
    reo_rail_gate #(
        .N(reo_pkg::NUM_RAILS)
    ) u_gate (
        .allow_in(allow_vec),
        .force_in(force_vec),
        .request_in(rail_request_in), // [R6]
        .enable_out(enable_vec)
    );

    // output levels: register bit when configured, else the power-good tree
    wire [reo_pkg::NUM_GPO-1:0] lvl_bits = force_b_r[reo_pkg::BIT_LVL_LO +: reo_pkg::NUM_GPO];
    logic [reo_pkg::NUM_GPO-1:0] gpo_level;
    logic [reo_pkg::NUM_GPO-1:0] gpo_pp;
    generate
        for (genvar g = 0; g < reo_pkg::NUM_GPO; g++) begin : g_gpo
            assign gpo_level[g] = gpo_reg_ctrl_in[g] ? lvl_bits[g] : gpo_power_good_in[g]; // [R15]
            if (g == reo_pkg::GPO_FOUR) begin : g_od
                // pin four has no push-pull stage, so high is only released
                assign gpo_pp[g] = 1'b0; // [R13]
            end else begin : g_cfg
                assign gpo_pp[g] = gpo_push_pull_in[g]; // [R14]
            end
        end
    endgenerate

    // every rail and gpo output leaves through a flop so a decode glitch never reaches a rail
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rail_en_out <= '0;
            load_switch_b2_en_out <= 1'b0;
            regulator_a1_en_out <= 1'b0;
            gpo_out <= '0;
            gpo_oe_out <= '0;
        end else begin
            rail_en_out <= enable_vec; // [R17]
            load_switch_b2_en_out <= enable_vec[reo_pkg::RAIL_SHARED] & shared_is_switch_b2_in;
            regulator_a1_en_out <= enable_vec[reo_pkg::RAIL_SHARED] & ~shared_is_switch_b2_in;
            gpo_out <= gpo_level & gpo_pp; // [R14]
            gpo_oe_out <= gpo_pp | ~gpo_level; // [R13]
        end
    end

    // open-drain data: the level stays low and only the enable moves
    assign sda_out = 1'b0;
    assign sda_oe_out = sda_oe_r;
endmodule : reo_top

// >>> reo_top_sva.sv
// port assertions for the rail enable override block
`timescale 1ns/100ps
module reo_top_sva (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [11:0] rail_request_in,
    input wire logic [5:0] buck_disable_in,
    input wire logic regulator_a2_disable_in,
    input wire logic regulator_a3_disable_in,
    input wire logic shared_is_switch_b2_in,
    input wire logic [3:0] gpo_reg_ctrl_in,
    input wire logic [3:0] gpo_push_pull_in,
    input wire logic [3:0] gpo_power_good_in,
    input wire logic [11:0] rail_en_out,
    input wire logic load_switch_b2_en_out,
    input wire logic regulator_a1_en_out,
    input wire logic [3:0] gpo_out,
    input wire logic [3:0] gpo_oe_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!nrst_in);
    property p_buck_off;
        (rail_en_out[5:0] & ~$past(buck_disable_in)) == 6'h00;
    endproperty
    a_buck_off: assert property (p_buck_off) else $error("buck on while disabled");
    property p_a2_off;
        !regulator_a2_disable_in |=> !rail_en_out[7];
    endproperty
    a_a2_off: assert property (p_a2_off) else $error("a2 on while disabled");
    property p_a3_off;
        !regulator_a3_disable_in |=> !rail_en_out[8];
    endproperty
    a_a3_off: assert property (p_a3_off) else $error("a3 on while disabled");
    // shared enable goes to exactly one of its two rails
    property p_shared;
        (load_switch_b2_en_out | regulator_a1_en_out) == rail_en_out[10]
            && !(load_switch_b2_en_out && regulator_a1_en_out);
    endproperty
    a_shared: assert property (p_shared) else $error("shared rail split wrong");
    property p_pg_pp;
        !gpo_reg_ctrl_in[0] && gpo_push_pull_in[0] |=>
            gpo_oe_out[0] && gpo_out[0] == $past(gpo_power_good_in[0]);
    endproperty
    a_pg_pp: assert property (p_pg_pp) else $error("output one ignores power good");
    property p_pg_od;
        !gpo_reg_ctrl_in[3] |=>
            !gpo_out[3] && gpo_oe_out[3] == !$past(gpo_power_good_in[3]);
    endproperty
    a_pg_od: assert property (p_pg_od) else $error("output four ignores power good");
    property p_four_od;
        gpo_reg_ctrl_in[3] |=> !gpo_out[3];
    endproperty
    a_four_od: assert property (p_four_od) else $error("output four driven high");
    property p_od_mode;
        !gpo_push_pull_in[2] |=> !gpo_out[2];
    endproperty
    a_od_mode: assert property (p_od_mode) else $error("open drain output driven");
    // reset must leave every rail off, no separate disable applies
    property p_quiet;
        disable iff (1'b0) !nrst_in |=> rail_en_out == 12'h000 && gpo_oe_out == 4'h0
            && !sda_oe_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("outputs active in reset");
    c_term: cover property (rail_en_out[11]);
    c_ack: cover property ($rose(sda_oe_out));
    c_four: cover property ($fell(gpo_oe_out[3]));
endmodule : reo_top_sva
bind reo_top reo_top_sva u_sva (
    .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .rail_request_in(rail_request_in),
    .buck_disable_in(buck_disable_in), .regulator_a2_disable_in(regulator_a2_disable_in),
    .regulator_a3_disable_in(regulator_a3_disable_in),
    .shared_is_switch_b2_in(shared_is_switch_b2_in), .gpo_reg_ctrl_in(gpo_reg_ctrl_in),
    .gpo_push_pull_in(gpo_push_pull_in), .gpo_power_good_in(gpo_power_good_in),
    .rail_en_out(rail_en_out), .load_switch_b2_en_out(load_switch_b2_en_out),
    .regulator_a1_en_out(regulator_a1_en_out), .gpo_out(gpo_out), .gpo_oe_out(gpo_oe_out)
);

// >>> test_reo_top.sv
// self-checking bench for the rail enable override block
`timescale 1ns/100ps
module test_reo_top;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic a2_dis = 1'b1;
    logic a3_dis = 1'b1;
    logic sel_b2 = 1'b1;
    logic [11:0] req = 12'h000;
    logic [5:0] buck_dis = 6'h3f;
    logic [3:0] g_ctl = 4'h0;
    logic [3:0] g_pp = 4'h0;
    logic [3:0] g_pg = 4'h0;
    logic scl, sda_drv, sda_zero, sda_oe, b2_en, a1_en;
    logic [11:0] rail_en;
    logic [3:0] g_out, g_oe;
    logic [7:0] q;
    logic [15:0] rq;
    logic [2:0] nak;
    wire sda_w = sda_drv & (sda_zero | ~sda_oe);
    int err_count = 0;
    int comparisons = 0;
    always #20 clk_in = ~clk_in;
    reo_host u_host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(sda_drv));
    reo_top u_dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_zero), .sda_oe_out(sda_oe), .rail_request_in(req),
        .buck_disable_in(buck_dis), .regulator_a2_disable_in(a2_dis),
        .regulator_a3_disable_in(a3_dis), .shared_is_switch_b2_in(sel_b2),
        .gpo_reg_ctrl_in(g_ctl), .gpo_push_pull_in(g_pp), .gpo_power_good_in(g_pg),
        .rail_en_out(rail_en), .load_switch_b2_en_out(b2_en),
        .regulator_a1_en_out(a1_en), .gpo_out(g_out), .gpo_oe_out(g_oe)
    );
    task automatic chk(input logic [11:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic w(input logic [7:0] p, d);
        u_host.wr(7'h5e, p, d, nak);
        chk({9'h000, nak}, 12'h000);
        u_host.tick(3);
    endtask : w
    task automatic rchk(input logic [7:0] p, e);
        u_host.rd(p, q);
        chk({4'h0, q}, {4'h0, e});
    endtask : rchk
    task automatic sc_regs();
        chk({11'h000, sda_zero}, 12'h000);
        rchk(8'h9f, 8'hf0);
        rchk(8'ha0, 8'h00);
        rchk(8'ha1, 8'h00);
        w(8'ha0, 8'h5a);
        rchk(8'ha0, 8'h5a);
        // master ack walks the pointer on to the next register
        u_host.rd2(8'h9f, rq);
        chk({4'h0, rq[15:8]}, 12'h0f0);
        chk({4'h0, rq[7:0]}, 12'h05a);
        rchk(8'h10, 8'h00);
        // foreign address must be ignored whole
        u_host.wr(7'h21, 8'ha0, 8'hff, nak);
        chk({9'h000, nak}, 12'h007);
        rchk(8'ha0, 8'h5a);
        w(8'ha0, 8'h00);
    endtask : sc_regs
    task automatic sc_force();
        w(8'ha0, 8'hff);
        chk(rail_en, 12'h0ff);
        buck_dis = 6'h3b;
        a2_dis = 1'b0;
        u_host.tick(3);
        chk(rail_en, 12'h07b);
        w(8'ha0, 8'h00);
        req = 12'hfff;
        u_host.tick(3);
        chk(rail_en, 12'hf7b);
        req = 12'h000;
        buck_dis = 6'h3f;
        a2_dis = 1'b1;
        u_host.tick(3);
        chk(rail_en, 12'h000);
    endtask : sc_force
    task automatic sc_disable();
        int idx [4] = '{11, 6, 9, 10};
        w(8'ha0, 8'h40);
        w(8'ha1, 8'h0f);
        chk(rail_en, 12'hf40);
        chk({10'h000, b2_en, a1_en}, 12'h002);
        for (int b = 4; b < 8; b++) begin
            w(8'h9f, 8'hf0 ^ (8'h01 << b));
            chk(rail_en, 12'hf40 & ~(12'h001 << idx[b-4]));
        end
        sel_b2 = 1'b0;
        a3_dis = 1'b0;
        w(8'h9f, 8'hf0);
        chk(rail_en, 12'he40);
        chk({10'h000, b2_en, a1_en}, 12'h001);
        a3_dis = 1'b1;
        w(8'ha1, 8'h00);
        w(8'ha0, 8'h00);
    endtask : sc_disable
    task automatic sc_gpo();
        g_ctl = 4'hf;
        g_pp = 4'h7;
        w(8'ha1, 8'ha0);
        chk({4'h0, g_oe, g_out}, 12'h072);
        w(8'ha1, 8'h50);
        chk({4'h0, g_oe, g_out}, 12'h0f5);
        g_ctl = 4'h0;
        g_pg = 4'h3;
        u_host.tick(3);
        chk({4'h0, g_oe, g_out}, 12'h0f3);
    endtask : sc_gpo
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (5) @(negedge clk_in);
        nrst_in = 1'b1;
        sc_regs();
        sc_force();
        sc_disable();
        sc_gpo();
        end_of_test();
    end
    initial begin
        repeat (100000) @(posedge clk_in);
        err_count++;
        end_of_test();
    end
endmodule : test_reo_top
